// ---- core/amd_map.svh ----
// Address map constants for the address map decoder
// Functional notes
// - One unified 64 KB address space
// - Code fetches always use even addresses
// - Byte and word data accesses supported
// - Program memory ends at 0FFFFh, start parameterised
// - Vector table: top 16 words, highest 0FFFEh
// - Program memory serves fetches and data reads
// - RAM starts 0200h, serves code and data
// - 0100h-01FFh is 16-bit peripheral region
// - Byte access there: even only, upper zero
// - 010h-0FFh is 8-bit peripheral region
// - Word read of 8-bit region: upper undefined
// - Word write to 8-bit region stores low byte
// - Lowest 16 bytes: special function bytes, byte-only
// - Little-endian: low byte at even address
// - Word accesses only at even addresses
`ifndef AMD_MAP_SVH
`define AMD_MAP_SVH
`define AMD_ADDR_W        16
`define AMD_SFB_END       16'h000F
`define AMD_P8_START      16'h0010
`define AMD_P8_END        16'h00FF
`define AMD_P16_START     16'h0100
`define AMD_P16_END       16'h01FF
`define AMD_RAM_START     16'h0200
`define AMD_RAM_END_DEF   16'h09FF
`define AMD_PROG_END      16'hFFFF
`define AMD_PROG_START_DEF 16'hC000
`define AMD_VEC_START     16'hFFE0
`define AMD_VEC_RESET     16'hFFFE
`endif

// ---- core/amd_pkg.sv ----
// Types used by the decoder end of the address map decoder
package amd_pkg;
  typedef enum logic [5:0] {
    AMD_RGN_SFB  = 6'b000001,
    AMD_RGN_P8   = 6'b000010,
    AMD_RGN_P16  = 6'b000100,
    AMD_RGN_RAM  = 6'b001000,
    AMD_RGN_PROG = 6'b010000,
    AMD_RGN_NONE = 6'b100000
  } amd_region_e;

  typedef enum logic [2:0] {
    AMD_ST_IDLE = 3'b001,
    AMD_ST_WAIT = 3'b010,
    AMD_ST_DONE = 3'b100
  } amd_state_e;
endpackage : amd_pkg

// ---- core/amd_bus_if.sv ----
// CPU-side bus between master end and decoder end
interface amd_bus_if;
  logic        req;
  logic        we;
  logic        word;
  logic        fetch;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        ack;
  logic        err;

  modport decoder (
    input  req,
    input  we,
    input  word,
    input  fetch,
    input  addr,
    input  wdata,
    output rdata,
    output ack,
    output err
  );

  modport master (
    output req,
    output we,
    output word,
    output fetch,
    output addr,
    output wdata,
    input  rdata,
    input  ack,
    input  err
  );
endinterface : amd_bus_if

// ---- core/amd_decoder.sv ----
// Address decoder: steers CPU accesses to each memory region
`include "amd_map.svh"
module amd_decoder #(
  parameter logic [15:0] RAM_END    = `AMD_RAM_END_DEF,
  parameter logic [15:0] PROG_START = `AMD_PROG_START_DEF
) (
  input  wire logic       clk,
  input  wire logic       rst,
  amd_bus_if.decoder      bus,
  output logic            sel_sfb,
  output logic            sel_p8,
  output logic            sel_p16,
  output logic            sel_ram,
  output logic            sel_prog,
  output logic            tgt_we,
  output logic [1:0]      tgt_be,
  output logic [15:0]     tgt_addr,
  output logic [15:0]     tgt_wdata,
  input  wire logic [15:0] tgt_rdata,
  input  wire logic       tgt_ack
);
  amd_pkg::amd_state_e  state;
  amd_pkg::amd_state_e  next_state;
  amd_pkg::amd_region_e region;
  amd_pkg::amd_region_e next_region;
  logic                 word_q;
  logic                 next_word_q;
  logic                 hi_q;
  logic                 next_hi_q;
  logic [15:0]          rdata_q;
  logic [15:0]          next_rdata_q;
  logic                 ack_q;
  logic                 next_ack_q;
  logic                 err_q;
  logic                 next_err_q;
  logic [4:0]           sel_q;
  logic [4:0]           next_sel_q;
  logic                 we_q;
  logic                 next_we_q;
  logic [1:0]           be_q;
  logic [1:0]           next_be_q;
  logic [15:0]          a_q;
  logic [15:0]          next_a_q;
  logic [15:0]          wd_q;
  logic [15:0]          next_wd_q;
  // Decode of the address on the bus this cycle
  amd_pkg::amd_region_e dec;
  logic                 bad;
  logic [1:0]           lane_be;
  logic [15:0]          lane_wd;
  logic [15:0]          lane_rd;

  // Full 16-bit address covers the whole 64 KB space
  always_comb begin
    if (bus.addr <= `AMD_SFB_END)
      dec = amd_pkg::AMD_RGN_SFB;
    else if (bus.addr <= `AMD_P8_END)
      dec = amd_pkg::AMD_RGN_P8;
    else if (bus.addr <= `AMD_P16_END)
      dec = amd_pkg::AMD_RGN_P16;
    else if (bus.addr <= RAM_END)
      dec = amd_pkg::AMD_RGN_RAM;
    else if (bus.addr >= PROG_START)
      dec = amd_pkg::AMD_RGN_PROG;
    else
      dec = amd_pkg::AMD_RGN_NONE;
  end

  // Misaligned words, odd fetches, word SFB and odd byte P16 are flagged
  always_comb begin
    bad = ((bus.word || bus.fetch) && bus.addr[0]);
    if (dec == amd_pkg::AMD_RGN_SFB && bus.word)
      bad = 1'b1;
    if (dec == amd_pkg::AMD_RGN_P16 && !bus.word && bus.addr[0])
      bad = 1'b1;
  end

  // Byte lanes: low byte at even address
  always_comb begin
    if (bus.word && dec == amd_pkg::AMD_RGN_P8)
      lane_be = 2'b01;
    else if (bus.word)
      lane_be = 2'b11;
    else
      lane_be = bus.addr[0] ? 2'b10 : 2'b01;
    // Byte data duplicated on both lanes so either lane can take it
    if (bus.word)
      lane_wd = bus.wdata;
    else
      lane_wd = {bus.wdata[7:0], bus.wdata[7:0]};
  end

  // Returned byte lands in the low half, upper half cleared
  always_comb begin
    if (word_q)
      lane_rd = tgt_rdata;
    else if (region == amd_pkg::AMD_RGN_P16)
      lane_rd = {8'h00, tgt_rdata[7:0]};
    else
      lane_rd = {8'h00, hi_q ? tgt_rdata[15:8] : tgt_rdata[7:0]};
  end

  // One access at a time; requests outside idle are ignored
  always_comb begin
    next_state   = state;
    next_region  = region;
    next_word_q  = word_q;
    next_hi_q    = hi_q;
    next_rdata_q = rdata_q;
    next_ack_q   = 1'b0;
    next_err_q   = 1'b0;
    next_sel_q   = sel_q;
    next_we_q    = we_q;
    next_be_q    = be_q;
    next_a_q     = a_q;
    next_wd_q    = wd_q;
    unique case (state)
      amd_pkg::AMD_ST_IDLE: begin
        if (bus.req) begin
          if (bad) begin
            // Refused: answered at once, no target is selected
            next_ack_q   = 1'b1;
            next_err_q   = 1'b1;
            next_rdata_q = 16'h0000;
          end else if (dec == amd_pkg::AMD_RGN_NONE) begin
            // Hole between RAM and program memory: reads zero, writes dropped
            next_ack_q   = 1'b1;
            next_rdata_q = 16'h0000;
          end else begin
            next_region = dec;
            next_word_q = bus.word;
            next_hi_q   = bus.addr[0];
            // Fetches never write
            next_we_q   = bus.we && !bus.fetch;
            // Address held even; the odd byte is picked by the lane enables
            next_a_q    = {bus.addr[15:1], 1'b0};
            next_sel_q  = dec[4:0];
            next_be_q   = lane_be;
            next_wd_q   = lane_wd;
            next_state  = amd_pkg::AMD_ST_WAIT;
          end
        end
      end
      amd_pkg::AMD_ST_WAIT: begin
        // No limit on target stalls; a dead target hangs the bus
        if (tgt_ack) begin
          next_sel_q   = 5'b00000;
          next_we_q    = 1'b0;
          next_rdata_q = lane_rd;
          next_ack_q   = 1'b1;
          next_state   = amd_pkg::AMD_ST_DONE;
        end
      end
      amd_pkg::AMD_ST_DONE: begin
        next_state = amd_pkg::AMD_ST_IDLE;
      end
      default: begin
        // Corrupt state code: drop the target and fall back to idle
        next_state = amd_pkg::AMD_ST_IDLE;
        next_sel_q = 5'b00000;
        next_we_q  = 1'b0;
        next_be_q  = 2'b00;
      end
    endcase
  end

  // Reset drops every target select before any access
  always_ff @(posedge clk) begin
    if (rst) begin
      state   <= amd_pkg::AMD_ST_IDLE;
      region  <= amd_pkg::AMD_RGN_NONE;
      word_q  <= 1'b0;
      hi_q    <= 1'b0;
      rdata_q <= 16'h0000;
      ack_q   <= 1'b0;
      err_q   <= 1'b0;
      sel_q   <= 5'b00000;
      we_q    <= 1'b0;
      be_q    <= 2'b00;
      a_q     <= 16'h0000;
      wd_q    <= 16'h0000;
    end else begin
      state   <= next_state;
      region  <= next_region;
      word_q  <= next_word_q;
      hi_q    <= next_hi_q;
      rdata_q <= next_rdata_q;
      ack_q   <= next_ack_q;
      err_q   <= next_err_q;
      sel_q   <= next_sel_q;
      we_q    <= next_we_q;
      be_q    <= next_be_q;
      a_q     <= next_a_q;
      wd_q    <= next_wd_q;
    end
  end

  // Every output comes straight from a register
  assign bus.rdata = rdata_q;
  assign bus.ack   = ack_q;
  assign bus.err   = err_q;
  assign sel_sfb   = sel_q[0];
  assign sel_p8    = sel_q[1];
  assign sel_p16   = sel_q[2];
  assign sel_ram   = sel_q[3];
  assign sel_prog  = sel_q[4];
  assign tgt_we    = we_q;
  assign tgt_be    = be_q;
  assign tgt_addr  = a_q;
  assign tgt_wdata = wd_q;
endmodule : amd_decoder

// ---- core/amd_master.sv ----
// CPU-side master end: issues one access per user request, none for a fetch from the special function bytes
`include "amd_map.svh"
module amd_master (
  input  wire logic        clk,
  input  wire logic        rst,
  amd_bus_if.master        bus,
  input  wire logic        usr_req,
  input  wire logic        usr_we,
  input  wire logic        usr_word,
  input  wire logic        usr_fetch,
  input  wire logic [15:0] usr_addr,
  input  wire logic [15:0] usr_wdata,
  output logic             usr_busy,
  output logic             usr_done,
  output logic             usr_err,
  output logic [15:0]      usr_rdata
);
  logic        busy;
  logic        next_busy;
  logic        req_q;
  logic        next_req_q;
  logic        we_q;
  logic        next_we_q;
  logic        word_q;
  logic        next_word_q;
  logic        fetch_q;
  logic        next_fetch_q;
  logic [15:0] a_q;
  logic [15:0] next_a_q;
  logic [15:0] wd_q;
  logic [15:0] next_wd_q;
  logic        done_q;
  logic        next_done_q;
  logic        err_q;
  logic        next_err_q;
  logic [15:0] rd_q;
  logic [15:0] next_rd_q;

  always_comb begin
    next_busy    = busy;
    next_req_q   = 1'b0;
    next_we_q    = we_q;
    next_word_q  = word_q;
    next_fetch_q = fetch_q;
    next_a_q     = a_q;
    next_wd_q    = wd_q;
    next_done_q  = 1'b0;
    next_err_q   = err_q;
    next_rd_q    = rd_q;
    if (!busy && usr_req) begin
      next_busy    = 1'b1;
      next_req_q   = 1'b1;
      next_we_q    = usr_we && !usr_fetch;
      next_fetch_q = usr_fetch;
      // Fetches are word wide at even addresses
      next_word_q  = usr_word || usr_fetch;
      next_a_q     = (usr_word || usr_fetch) ? {usr_addr[15:1], 1'b0} : usr_addr;
      // Special function bytes only ever see byte access
      if (usr_addr <= `AMD_SFB_END && !usr_fetch)
        next_word_q = 1'b0;
      if (usr_addr <= `AMD_SFB_END && !usr_fetch)
        next_a_q = usr_addr;
      next_wd_q = usr_wdata;
      // No code lives in the special function bytes: refused here, no bus access
      if (usr_addr <= `AMD_SFB_END && usr_fetch) begin
        next_busy   = 1'b0;
        next_req_q  = 1'b0;
        next_done_q = 1'b1;
        next_err_q  = 1'b1;
        next_rd_q   = 16'h0000;
      end
    end else if (busy && bus.ack) begin
      next_busy   = 1'b0;
      next_done_q = 1'b1;
      next_err_q  = bus.err;
      // Upper byte of a word read from 8-bit space is not trusted
      if (word_q && a_q >= `AMD_P8_START && a_q <= `AMD_P8_END)
        next_rd_q = {8'h00, bus.rdata[7:0]};
      else
        next_rd_q = bus.rdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      busy    <= 1'b0;
      req_q   <= 1'b0;
      we_q    <= 1'b0;
      word_q  <= 1'b0;
      fetch_q <= 1'b0;
      a_q     <= 16'h0000;
      wd_q    <= 16'h0000;
      done_q  <= 1'b0;
      err_q   <= 1'b0;
      rd_q    <= 16'h0000;
    end else begin
      busy    <= next_busy;
      req_q   <= next_req_q;
      we_q    <= next_we_q;
      word_q  <= next_word_q;
      fetch_q <= next_fetch_q;
      a_q     <= next_a_q;
      wd_q    <= next_wd_q;
      done_q  <= next_done_q;
      err_q   <= next_err_q;
      rd_q    <= next_rd_q;
    end
  end

  assign bus.req   = req_q;
  assign bus.we    = we_q;
  assign bus.word  = word_q;
  assign bus.fetch = fetch_q;
  assign bus.addr  = a_q;
  assign bus.wdata = wd_q;
  assign usr_busy  = busy;
  assign usr_done  = done_q;
  assign usr_err   = err_q;
  assign usr_rdata = rd_q;
endmodule : amd_master

// ---- tb/amd_asserts.sv ----
// Bus protocol checker for the address map decoder interface
module amd_asserts #(
  parameter logic [15:0] RAM_END    = 16'h09FF,
  parameter logic [15:0] PROG_START = 16'hC000
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        req,
  input wire logic        we,
  input wire logic        word,
  input wire logic        fetch,
  input wire logic [15:0] addr,
  input wire logic [15:0] rdata,
  input wire logic        ack,
  input wire logic        err
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_odd_word_refused: assert property (req && word && addr[0] |=> ack && err)
    else $error("odd word access not refused");
  a_sfb_byte_only: assert property (req && addr <= 16'h000F |-> !word)
    else $error("word access to special function bytes");
  a_p16_odd_byte: assert property (req && !word && addr[15:8] == 8'h01 && addr[0] |=> ack && err)
    else $error("odd byte in 16-bit region not refused");
  a_gap_reads_zero: assert property (req && addr > RAM_END && addr < PROG_START && !(word && addr[0])
    |=> ack && !err && rdata == 16'h0000) else $error("gap access not answered with zero");
  a_fetch_even: assert property (req && fetch |-> word && !addr[0] && !we)
    else $error("fetch not an even word read");
  a_ack_bounded: assert property (req |-> ##[1:8] ack)
    else $error("access not answered");
  a_ack_single: assert property (ack |=> !ack)
    else $error("answer longer than one cycle");
  a_refused_no_data: assert property (ack && err |-> rdata == 16'h0000)
    else $error("refused access returned data");
  a_rdata_held: assert property (!ack |-> $stable(rdata))
    else $error("read data changed without answer");
  a_word_even: assert property (req && word |-> !addr[0])
    else $error("word access at odd address");

  c_write: cover property (req && we);
  c_fetch: cover property (req && fetch);
  c_refused: cover property (ack && err);
  c_hole: cover property (req && addr > RAM_END && addr < PROG_START);
endmodule : amd_asserts

// ---- tb/address_map_decoder_tb_top.sv ----
// Bench joining master and decoder ends over a byte memory target
module address_map_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] RAM_END    = 16'h09FF;
  localparam logic [15:0] PROG_START = 16'hC000;
  logic        clk = 1'b0, rst = 1'b1, usr_req = 1'b0, usr_we = 1'b0, usr_word = 1'b0, usr_fetch = 1'b0;
  logic [15:0] usr_addr = 16'h0000, usr_wdata = 16'h0000, tgt_rdata = 16'h0000;
  logic        tgt_ack = 1'b0, usr_busy, usr_done, usr_err, tgt_we;
  logic [15:0] usr_rdata, tgt_addr, tgt_wdata;
  logic [1:0]  tgt_be;
  logic [4:0]  sel;
  logic [7:0]  mem [0:65535];
  logic [7:0]  exp_mem [0:65535];
  int          err_total = 0, comparisons = 0, seed = 32'h6EC4, wait_n = 0;

  amd_bus_if bus_if ();
  amd_master i_amd_master (.clk(clk), .rst(rst), .bus(bus_if), .usr_req(usr_req), .usr_we(usr_we),
    .usr_word(usr_word), .usr_fetch(usr_fetch), .usr_addr(usr_addr), .usr_wdata(usr_wdata),
    .usr_busy(usr_busy), .usr_done(usr_done), .usr_err(usr_err), .usr_rdata(usr_rdata));
  amd_decoder #(.RAM_END(RAM_END), .PROG_START(PROG_START)) i_amd_decoder (.clk(clk), .rst(rst),
    .bus(bus_if), .sel_sfb(sel[0]), .sel_p8(sel[1]), .sel_p16(sel[2]), .sel_ram(sel[3]), .sel_prog(sel[4]),
    .tgt_we(tgt_we), .tgt_be(tgt_be), .tgt_addr(tgt_addr), .tgt_wdata(tgt_wdata), .tgt_rdata(tgt_rdata),
    .tgt_ack(tgt_ack));
  amd_asserts #(.RAM_END(RAM_END), .PROG_START(PROG_START)) i_amd_asserts (.clk(clk), .rst(rst),
    .req(bus_if.req), .we(bus_if.we), .word(bus_if.word), .fetch(bus_if.fetch), .addr(bus_if.addr),
    .rdata(bus_if.rdata), .ack(bus_if.ack), .err(bus_if.err));

  always #4 clk = ~clk;

  // Target waits 0 to 2 cycles; read data scrambled outside answers so stale data never matches
  always @(negedge clk) begin
    if (tgt_ack || !(|sel)) begin
      tgt_ack <= 1'b0;
      tgt_rdata <= ~tgt_rdata;
      wait_n <= $unsigned($random(seed)) % 3;
    end else if (wait_n != 0) begin
      wait_n <= wait_n - 1;
    end else begin
      tgt_ack <= 1'b1;
      tgt_rdata <= {mem[tgt_addr | 16'h0001], mem[tgt_addr]};
      if (tgt_we && tgt_be[0]) mem[tgt_addr] <= tgt_wdata[7:0];
      if (tgt_we && tgt_be[1]) mem[tgt_addr | 16'h0001] <= tgt_wdata[15:8];
    end
  end

  task automatic stop_test();
    if (err_total == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      $display("BAD %s expected %h seen %h", name, exp, seen);
      err_total++;
    end
  endtask : check

  // Returns {err, read data}; writes land only where the map lets them
  function automatic logic [16:0] predict(input logic we, input logic w, input logic [15:0] a, input logic [15:0] wd);
    logic p8;
    p8 = a >= 16'h0010 && a <= 16'h00FF;
    if (w && a <= 16'h000F) return {1'b1, 16'h0000};
    if (a[0] && (w || a[15:8] == 8'h01)) return {1'b1, 16'h0000};
    if (a > RAM_END && a < PROG_START) return 17'h00000;
    if (we) begin
      exp_mem[a] = wd[7:0];
      if (w && !p8) exp_mem[a + 16'h0001] = wd[15:8];
      return 17'h00000;
    end
    return {1'b0, (w && !p8) ? exp_mem[a + 16'h0001] : 8'h00, exp_mem[a]};
  endfunction : predict

  // One-hot select the map gives an aligned address; zero in the hole
  function automatic logic [4:0] region_sel(input logic [15:0] a);
    if (a <= 16'h000F) return 5'b00001;
    if (a <= 16'h00FF) return 5'b00010;
    if (a <= 16'h01FF) return 5'b00100;
    if (a <= RAM_END) return 5'b01000;
    if (a >= PROG_START) return 5'b10000;
    return 5'b00000;
  endfunction : region_sel

  task automatic access(input logic we, input logic word, input logic fetch, input logic [15:0] a,
                        input logic [15:0] wd);
    logic [16:0] e;
    logic        w;
    logic [15:0] aa;
    logic [4:0]  seen_sel;
    logic [4:0]  exp_sel;
    int          n;
    // Master sends fetches and non-special words as even-aligned words
    w = fetch || (word && a > 16'h000F);
    aa = w ? {a[15:1], 1'b0} : a;
    e = predict(we && !fetch, w, aa, wd);
    exp_sel = e[16] ? 5'b00000 : region_sel(aa);
    seen_sel = 5'b00000;
    usr_req = 1'b1;
    usr_we = we;
    usr_word = word;
    usr_fetch = fetch;
    usr_addr = a;
    usr_wdata = wd;
    @(negedge clk);
    usr_req = 1'b0;
    n = 0;
    while (usr_done !== 1'b1 && n < 40) begin
      @(negedge clk);
      if (|sel) seen_sel = sel;
      n++;
    end
    check("done", {15'h0000, usr_done}, 16'h0001);
    check("busy", {15'h0000, usr_busy}, 16'h0000);
    check("sel", {11'h000, seen_sel}, {11'h000, exp_sel});
    check("err", {15'h0000, usr_err}, {15'h0000, e[16]});
    if (!we || fetch) check("rdata", usr_rdata, e[15:0]);
    @(negedge clk);
  endtask : access

  initial begin
    logic [15:0] a;
    static logic [15:0] corners [12] = '{16'h0000, 16'h000E, 16'h0010, 16'h00FE, 16'h0100, 16'h01FE, 16'h0200,
      RAM_END - 16'h0001, RAM_END + 16'h0001, PROG_START, 16'hFFE0, 16'hFFFE};
    for (int i = 0; i < 65536; i++) begin
      mem[i] = i[7:0] ^ i[15:8];
      exp_mem[i] = mem[i];
    end
    repeat (3) @(negedge clk);
    rst = 1'b0;
    foreach (corners[i]) begin
      a = corners[i];
      access(1'b1, 1'b1, 1'b0, a, $random(seed));
      access(1'b0, 1'b1, 1'b0, a, 16'h0000);
      access(1'b0, 1'b0, 1'b0, a | 16'h0001, 16'h0000);
      access(1'b0, 1'b1, 1'b0, a | 16'h0001, 16'h0000);
      access(1'b0, 1'b1, 1'b1, a, 16'h0000);
      access(1'b1, 1'b0, 1'b0, a | 16'h0001, $random(seed));
    end
    repeat (400) begin
      a = $random(seed);
      if (a[14]) a[15:10] = 6'h00;
      if (a[13]) access(1'b0, 1'b1, 1'b1, a & 16'hFFFE, 16'h0000);
      else access($random(seed), $random(seed), 1'b0, a, $random(seed));
    end
    stop_test();
  end

  // Cut a hang well beyond the expected run of some 2500 cycles
  initial begin
    #160000;
    err_total++;
    stop_test();
  end
endmodule : address_map_decoder_tb_top
